// ### verilog/vcorb_bank.sv
`timescale 1ns/1ps
`include "vcorb_defines.svh"
// Notes on behaviour
// - Subsystem registers are written only through the offset 0x05 forwarded write.
// - Word bits 2:0 hold the subsystem identifier; zero selects this bank.
// - Word bits 6:3 hold the target subsystem register address.
// - Register data sits from word bit 7 upward.
// - The four registers are write only; no read-back path exists.
// - Tuning bit 0 swaps tune voltage for compensated reference; default 0.
// - Tuning bits 8:1 select subband, zero highest; default 16.
// - Enable bit 0 low switches off the whole subsystem.
// - Enable bit 1 gates oscillators; bit 2 gates feedback buffer.
// - Enable bit 3 gates output stage and divider, not the oscillator.
// - Enable bit 5 low disables only output stage; all bits default 1.
// - Divider bits 5:0 give ratio; 1 passes, even N divides; default 1.
// - Odd ratios above 1 round down to even; above 62 becomes 62.
// - Divider zero mutes only while mute policy is 00.
// - Config bits 1:0 pick performance mode; default 2.
// - Config bits 2 and 3 enable negative and positive outputs; default 0.
// - Config bit 5 selects return loss; default 0.
// - Config bits 8:7 mute policy; default 01; 11 always mutes.
module vcorb_bank import vcorb_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // Forwarded register write
  input wire logic wr_en,
  input wire logic [4:0] wr_offset,
  input wire logic [15:0] wr_word,
  // Analog status
  input wire logic cal_active,
  // Tuning controls
  output logic tune_to_reference,
  output logic [7:0] subband_select,
  // Block enables
  output logic osc_enable,
  output logic fb_buffer_enable,
  output logic out_divider_enable,
  output logic out_stage_enable,
  // Divider and output
  output logic [5:0] divide_ratio,
  output logic [1:0] perf_mode,
  output logic negative_rf_output,
  output logic positive_rf_output,
  output logic high_return_loss,
  output logic rf_mute
);

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------
  vcorb_wr_if wr ();

  vcorb_decode u_decode (
    .wr_en(wr_en),
    .wr_offset(wr_offset),
    .wr_word(wr_word),
    .wr(wr)
  );

  // ---------------------------------------------------------------
  // Write-only registers
  // ---------------------------------------------------------------
  vcorb_word_type tuning_q, enables_q, divider_q, config_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      tuning_q <= `VCORB_TUNING_RST;
      enables_q <= `VCORB_ENABLES_RST;
      divider_q <= `VCORB_DIVIDER_RST;
      config_q <= `VCORB_CONFIG_RST;
    end else if (ce) begin
      if (wr.wr_tuning) tuning_q <= wr.data;
      if (wr.wr_enables) enables_q <= wr.data;
      if (wr.wr_divider) divider_q <= wr.data;
      if (wr.wr_config) config_q <= wr.data;
    end
  end

  // ---------------------------------------------------------------
  // Divider mapping
  // ---------------------------------------------------------------
  wire [5:0] eff_ratio;
  wire div_zero;

  vcorb_divmap u_divmap (
    .raw(divider_q[5:0]),
    .ratio(eff_ratio),
    .is_zero(div_zero)
  );

  // ---------------------------------------------------------------
  // Enable and mute combine
  // ---------------------------------------------------------------
  wire master = enables_q[`VCORB_EN_MASTER_BIT];
  wire io_master = master && enables_q[`VCORB_EN_IOMASTER_BIT];
  vcorb_mute_type mute_mode;
  assign mute_mode = vcorb_mute_type'(config_q[8:7]);
  wire mute_d = (mute_mode == VCORB_MUTE_ALWAYS)
    || (mute_mode == VCORB_MUTE_ZERO_DIV && div_zero)
    || (mute_mode == VCORB_MUTE_DURING_CAL && cal_active);

  // ---------------------------------------------------------------
  // Output flops
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      tune_to_reference <= 1'b0;
      subband_select <= 8'h10;
      osc_enable <= 1'b1;
      fb_buffer_enable <= 1'b1;
      out_divider_enable <= 1'b1;
      out_stage_enable <= 1'b1;
      divide_ratio <= 6'h01;
      perf_mode <= 2'h2;
      negative_rf_output <= 1'b0;
      positive_rf_output <= 1'b0;
      high_return_loss <= 1'b0;
      rf_mute <= 1'b0;
    end else if (ce) begin
      tune_to_reference <= tuning_q[`VCORB_TUNE_CAL_BIT];
      subband_select <= tuning_q[8:1];
      osc_enable <= master && enables_q[`VCORB_EN_OSC_BIT];
      fb_buffer_enable <= master && enables_q[`VCORB_EN_FBBUF_BIT];
      out_divider_enable <= io_master;
      out_stage_enable <= io_master && enables_q[`VCORB_EN_OUTSTAGE_BIT];
      divide_ratio <= eff_ratio;
      perf_mode <= config_q[1:0];
      negative_rf_output <= config_q[`VCORB_CFG_NEG_BIT];
      positive_rf_output <= config_q[`VCORB_CFG_POS_BIT];
      high_return_loss <= config_q[`VCORB_CFG_RLOSS_BIT];
      rf_mute <= mute_d;
    end
  end

endmodule // vcorb_bank

// ### inc/vcorb_defines.svh
`ifndef VCORB_DEFINES_SVH
`define VCORB_DEFINES_SVH

// -----------------------------------------------------------------
// Indirect write word layout
// -----------------------------------------------------------------
`define VCORB_IND_OFFSET 5'h05
`define VCORB_ID_LSB 0
`define VCORB_ID_MSB 2
`define VCORB_ADDR_LSB 3
`define VCORB_ADDR_MSB 6
`define VCORB_DATA_LSB 7
`define VCORB_DATA_MSB 15
`define VCORB_SUBSYS_ID 3'h0

// -----------------------------------------------------------------
// Subsystem register addresses
// -----------------------------------------------------------------
`define VCORB_REG_TUNING 4'h0
`define VCORB_REG_ENABLES 4'h1
`define VCORB_REG_DIVIDER 4'h2
`define VCORB_REG_CONFIG 4'h3

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define VCORB_TUNING_RST 9'h020
`define VCORB_ENABLES_RST 9'h1ff
`define VCORB_DIVIDER_RST 9'h001
`define VCORB_CONFIG_RST 9'h092

// -----------------------------------------------------------------
// Field positions and limits
// -----------------------------------------------------------------
`define VCORB_TUNE_CAL_BIT 0
`define VCORB_EN_MASTER_BIT 0
`define VCORB_EN_OSC_BIT 1
`define VCORB_EN_FBBUF_BIT 2
`define VCORB_EN_IOMASTER_BIT 3
`define VCORB_EN_OUTSTAGE_BIT 5
`define VCORB_CFG_NEG_BIT 2
`define VCORB_CFG_POS_BIT 3
`define VCORB_CFG_RLOSS_BIT 5
`define VCORB_DIV_MAX 6'h3e

`endif

// ### inc/vcorb_pkg.sv
package vcorb_pkg;

  typedef enum logic [1:0] {
    VCORB_MUTE_ZERO_DIV,
    VCORB_MUTE_DURING_CAL,
    VCORB_MUTE_UNSUPPORTED,
    VCORB_MUTE_ALWAYS
  } vcorb_mute_type;

  typedef enum logic [1:0] {
    VCORB_PERF_BAD0,
    VCORB_PERF_LOW_CURRENT,
    VCORB_PERF_BAD2,
    VCORB_PERF_HIGH
  } vcorb_perf_type;

  typedef logic [8:0] vcorb_word_type;

endpackage

// ### inc/vcorb_wr_if.sv
`timescale 1ns/1ps
interface vcorb_wr_if;
  logic wr_tuning;
  logic wr_enables;
  logic wr_divider;
  logic wr_config;
  logic [8:0] data;
  modport src (output wr_tuning, output wr_enables, output wr_divider, output wr_config, output data);
  modport dst (input wr_tuning, input wr_enables, input wr_divider, input wr_config, input data);
endinterface

// ### verilog/vcorb_decode.sv
`timescale 1ns/1ps
`include "vcorb_defines.svh"
module vcorb_decode import vcorb_pkg::*; (
  // Forwarded write
  input wire logic wr_en,
  input wire logic [4:0] wr_offset,
  input wire logic [15:0] wr_word,
  // Decoded strobes
  vcorb_wr_if.src wr
);
  wire hit = wr_en && wr_offset == `VCORB_IND_OFFSET;
  wire id_ok = wr_word[`VCORB_ID_MSB:`VCORB_ID_LSB] == `VCORB_SUBSYS_ID;
  wire [3:0] sub_addr = wr_word[`VCORB_ADDR_MSB:`VCORB_ADDR_LSB];
  wire sel = hit && id_ok;
  assign wr.wr_tuning = sel && sub_addr == `VCORB_REG_TUNING;
  assign wr.wr_enables = sel && sub_addr == `VCORB_REG_ENABLES;
  assign wr.wr_divider = sel && sub_addr == `VCORB_REG_DIVIDER;
  assign wr.wr_config = sel && sub_addr == `VCORB_REG_CONFIG;
  assign wr.data = wr_word[`VCORB_DATA_MSB:`VCORB_DATA_LSB];
endmodule // vcorb_decode

// ### verilog/vcorb_divmap.sv
`timescale 1ns/1ps
`include "vcorb_defines.svh"
module vcorb_divmap import vcorb_pkg::*; (
  // Raw ratio field
  input wire logic [5:0] raw,
  // Effective ratio, zero flag
  output logic [5:0] ratio,
  output logic is_zero
);
  wire [5:0] clipped = (raw > `VCORB_DIV_MAX) ? `VCORB_DIV_MAX : raw;
  wire odd_big = clipped[0] && clipped != 6'h01;
  assign ratio = odd_big ? {clipped[5:1], 1'b0} : clipped;
  assign is_zero = raw == 6'h00;
endmodule // vcorb_divmap

// ### verif/vcorb_pll_fwd.sv
`timescale 1ns/1ps
module vcorb_pll_fwd (
  input wire logic clk,
  input wire logic go,
  input wire logic [2:0] id,
  input wire logic [3:0] adr,
  input wire logic [8:0] dat,
  input wire logic [4:0] off,
  output logic wr_en,
  output logic [4:0] wr_offset,
  output logic [15:0] wr_word
);
  initial begin
    wr_en = 1'b0;
    wr_offset = 5'h00;
    wr_word = 16'h0000;
  end
  // Idle cycles scramble the released word
  always @(posedge clk) begin
    wr_en <= go;
    wr_offset <= go ? off : ~wr_offset;
    wr_word <= go ? {dat, adr, id} : ~wr_word;
  end
endmodule // vcorb_pll_fwd

// ### verif/vcorb_bank_assertions.sv
`timescale 1ns/1ps
module vcorb_bank_assertions (
  input wire logic clk, rst, ce, wr_en, cal_active,
  input wire logic [4:0] wr_offset,
  input wire logic [15:0] wr_word,
  input wire logic tune_to_reference, osc_enable, fb_buffer_enable, out_divider_enable, out_stage_enable,
  input wire logic negative_rf_output, positive_rf_output, high_return_loss, rf_mute,
  input wire logic [7:0] subband_select,
  input wire logic [5:0] divide_ratio,
  input wire logic [1:0] perf_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [15:0] w1, w2;
  wire ok = ce && wr_en && wr_offset == 5'h05 && wr_word[2:0] == 3'h0;
  wire [3:0] tk = {4{ok}} & (4'h1 << wr_word[6:3]);
  always_ff @(posedge clk) begin
    w1 <= wr_word;
    w2 <= w1;
  end
  function automatic logic [5:0] dmap(input logic [5:0] r);
    return (r > 6'h3e) ? 6'h3e : (r > 6'h01) ? {r[5:1], 1'b0} : r;
  endfunction
  a_tune_fields: assert property (tk[0] |-> ##2 {subband_select, tune_to_reference} == w2[15:7])
    else $error("tuning fields wrong");
  a_master_off: assert property (tk[1] && !wr_word[7] |-> ##2 !(osc_enable | fb_buffer_enable | out_divider_enable | out_stage_enable))
    else $error("master enable ignored");
  a_enable_gates: assert property (tk[1] && wr_word[7] |-> ##2
    {osc_enable, fb_buffer_enable, out_divider_enable, out_stage_enable} == {w2[8], w2[9], w2[10], w2[10] & w2[12]})
    else $error("enable gating wrong");
  a_div_map: assert property (tk[2] |-> ##2 divide_ratio == dmap(w2[12:7]))
    else $error("divide ratio wrong");
  a_cfg_fields: assert property (tk[3] |-> ##2
    {perf_mode, negative_rf_output, positive_rf_output, high_return_loss} == {w2[8:7], w2[9], w2[10], w2[12]})
    else $error("config fields wrong");
  a_mute_always: assert property (tk[3] && wr_word[15:14] == 2'h3 |-> ##2 rf_mute)
    else $error("unconditional mute missing");
  a_change_cause: assert property (!$stable(divide_ratio) |-> $past(tk[2], 2))
    else $error("divider changed without write");
  a_ce_freeze: assert property (!ce |=> $stable(subband_select) && $stable(divide_ratio))
    else $error("state moved while frozen");
endmodule // vcorb_bank_assertions
bind vcorb_bank vcorb_bank_assertions i_chk (.*);

// ### verif/tb_top.sv
`timescale 1ns/1ps
`include "vcorb_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top import vcorb_pkg::*;;
  logic clk = 0, rst = 1, ce = 1, cal = 0, go = 0;
  logic [2:0] id = 0;
  logic [3:0] adr = 0;
  logic [4:0] off = 5'h05;
  vcorb_word_type dat = 0;
  vcorb_word_type sh [4] = '{`VCORB_TUNING_RST, `VCORB_ENABLES_RST, `VCORB_DIVIDER_RST, `VCORB_CONFIG_RST};
  int seed = 32'hda9f;
  int n_fail = 0;
  int check_count = 0;
  logic wr_en;
  logic [4:0] wr_offset;
  logic [15:0] wr_word;
  wire [24:0] got;
  always #4 clk = ~clk;
  vcorb_pll_fwd i_fwd (.clk(clk), .go(go), .id(id), .adr(adr), .dat(dat), .off(off), .wr_en(wr_en),
    .wr_offset(wr_offset), .wr_word(wr_word));
  vcorb_bank i_dut (.clk(clk), .rst(rst), .ce(ce), .wr_en(wr_en), .wr_offset(wr_offset), .wr_word(wr_word),
    .cal_active(cal), .tune_to_reference(got[24]), .subband_select(got[23:16]), .osc_enable(got[15]),
    .fb_buffer_enable(got[14]), .out_divider_enable(got[13]), .out_stage_enable(got[12]), .divide_ratio(got[11:6]),
    .perf_mode(got[5:4]), .negative_rf_output(got[3]), .positive_rf_output(got[2]), .high_return_loss(got[1]),
    .rf_mute(got[0]));
  function automatic logic [5:0] dmap(input logic [5:0] r);
    return (r > 6'h3e) ? 6'h3e : (r > 6'h01) ? {r[5:1], 1'b0} : r;
  endfunction
  function automatic logic [24:0] expv(input logic c);
    logic m;
    logic [1:0] p;
    m = sh[1][0];
    p = sh[3][8:7];
    return {sh[0][0], sh[0][8:1], m & sh[1][1], m & sh[1][2], m & sh[1][3], m & sh[1][3] & sh[1][5], dmap(sh[2][5:0]),
      sh[3][1:0], sh[3][2], sh[3][3], sh[3][5], p == 2'h3 || (p == 2'h1 && c) || (p == 2'h0 && sh[2][5:0] == 6'h00)};
  endfunction
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Full nine-bit write, then compare every output
  task automatic wr(input logic [3:0] a, input vcorb_word_type d, input logic [2:0] i, input logic [4:0] o,
    input logic e, input logic c);
    @(posedge clk);
    go <= 1'b1;
    adr <= a;
    dat <= d;
    id <= i;
    off <= o;
    ce <= e;
    cal <= c;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    if (e && i == 3'h0 && o == 5'h05 && a < 4'h4) sh[a[1:0]] = d;
    `CHK("outputs", expv(c), got)
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict;
  end
  initial begin
    logic [3:0] a;
    vcorb_word_type d;
    logic e;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK("reset", expv(1'b0), got)
    $display("test reset done");
    wr(4'h1, 9'h1df, 3'h0, 5'h05, 1'b1, 1'b0);
    for (int p = 3; p >= 0; p--) wr(4'h3, {p[1:0], 7'h1f}, 3'h0, 5'h05, 1'b1, 1'b1);
    $display("test mute policy done");
    for (int k = 0; k < 64; k++) wr(4'h2, 9'(k), 3'h0, 5'h05, 1'b1, 1'b0);
    $display("test divider sweep done");
    for (int n = 0; n < 300; n++) begin
      a = 4'($unsigned($random(seed)) % 6);
      d = 9'($random(seed));
      if (a == 4'h1) d = d | 9'h1d0;
      if (a == 4'h3) d[0] = 1'b1;
      e = ($random(seed) % 8) != 0;
      wr(a, d, ($random(seed) % 4 == 0) ? 3'($random(seed)) : 3'h0, ($random(seed) % 4 == 0) ? 5'($random(seed)) : 5'h05,
        e, e ? 1'($random(seed)) : cal);
    end
    $display("test random traffic done");
    print_verdict;
  end
endmodule // tb_top
